// >>> design/srwa_pkg.sv
package srwa_pkg;

  // detector, select, delay and result widths
  localparam int unsigned POS_W = 24;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned DLY_W = 8;
  localparam int unsigned RES_W = 17;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CLK_CTRL = 10'h029;
  localparam logic [9:0] IDX_POS_LOW  = 10'h02c;
  localparam logic [9:0] IDX_POS_MID  = 10'h02d;
  localparam logic [9:0] IDX_POS_HIGH = 10'h02e;
  localparam logic [9:0] IDX_TAD      = 10'h030;
  localparam logic [9:0] IDX_CAL_EN   = 10'h031;
  localparam logic [9:0] IDX_CAL_CFG  = 10'h032;
  localparam logic [9:0] IDX_CAL_STAT = 10'h033;

  // field positions
  localparam int unsigned CTRL_SEL_LSB   = 0;
  localparam int unsigned CTRL_FINE_BIT  = 4;
  localparam int unsigned DLY_FINE_LSB   = 0;
  localparam int unsigned DLY_COARSE_LSB = 8;
  localparam int unsigned DLY_INV_BIT    = 16;
  localparam int unsigned EN_BIT         = 0;
  localparam int unsigned STAT_DONE_BIT  = 0;
  localparam int unsigned STAT_FAIL_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT  = 2;
  localparam int unsigned STAT_RES_LSB   = 8;

  // reset values and delay maximum
  localparam logic [3:0] RST_SEL       = 4'h0;
  localparam logic       RST_STEP_FINE = 1'b1;
  localparam logic [7:0] RST_CFG       = 8'h01;
  localparam logic [7:0] RST_DLY       = 8'h00;
  localparam logic [7:0] DLY_MAX       = 8'hff;

  // settling time after each delay step, least time so rounded up
  localparam int unsigned CLK_NS     = 20;
  localparam int unsigned SETTLE_NS  = 100;
  localparam int unsigned SETTLE_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  SETTLE_CYC =
    8'((SETTLE_RAW < 1) ? 1 : SETTLE_RAW);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_COARSE = 4'h2,
    ST_FINE   = 4'h4,
    ST_DONE   = 4'h8
  } srwa_state_e;

endpackage

// >>> design/srwa_position_detector.sv
`timescale 1ns/1ps
module srwa_position_detector (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [23:0] tap_raw_i,
  output logic      [23:0] tap_sync_o,
  output logic      [23:0] flags_o
);

  typedef struct packed {
    logic [23:0] s1;
    logic [23:0] s2;
    logic [23:0] flags;
  } srwa_det_s;

  srwa_det_s   q_ff;
  srwa_det_s   nxt_q;
  logic [23:0] flag_calc;

  genvar k;
  generate
    for (k = 0; k < srwa_pkg::POS_W; k++)
    begin : g_pos
      if (k == 0 || k == srwa_pkg::POS_W - 1)
      begin : g_edge
        assign flag_calc[k] = 1'b1;
      end
      else
      begin : g_mid
        assign flag_calc[k] = (q_ff.s2[k] ^ q_ff.s2[k-1]) |
                              (q_ff.s2[k] ^ q_ff.s2[k+1]);
      end
    end
  endgenerate

  always_comb
  begin
    nxt_q       = q_ff;
    nxt_q.s1    = tap_raw_i;
    nxt_q.s2    = q_ff.s1;
    nxt_q.flags = flag_calc;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign tap_sync_o = q_ff.s2;
  assign flags_o    = q_ff.flags;

  property p_flag_ends;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 1) |-> flags_o[0] && flags_o[23];
  endproperty
  a_flag_ends: assert property (p_flag_ends)
    else $error("outer position flags not set");

  property p_flag_live;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3) |->
      flags_o[5] == (($past(tap_raw_i[5], 3) ^ $past(tap_raw_i[4], 3)) |
                     ($past(tap_raw_i[5], 3) ^ $past(tap_raw_i[6], 3)));
  endproperty
  a_flag_live: assert property (p_flag_live)
    else $error("position flag does not follow the taps");

endmodule

// >>> design/srwa_sysref_window_autocal.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// - detect reference position and keep one flag per delayed sample position
// - flag one means setup or hold risk there, zero means valid
// - software writes select index, device samples reference at that tap
// - select reaches positions 0 to 15 only, upper flags informational
// - flags 0 and 23 read as one, except in the first cycle after reset
// - step-fine bit zero gives coarse detector steps, one gives fine
// - enable starts delay search until clock fall meets reference rise
// - done flag raised when search ends, software polls it
// - found delay setting readable in calibration status
// - calibrated delay kept; manual tuning allowed once calibration disabled
// - search both polarities, choose smallest coarse delay
// - invert bit adds half period; coarse and fine have 256 settings
module srwa_sysref_window_autocal (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [23:0] tap_raw_i,
  input  wire logic        clk_fall_leads_i,
  output logic      [3:0]  reference_sample_select_o,
  output logic             position_step_fine_o,
  output logic             sysref_captured_o,
  output logic             clock_invert_delay_o,
  output logic      [7:0]  aperture_coarse_delay_o,
  output logic      [7:0]  aperture_fine_delay_o,
  output logic             refcal_done_o
);

  typedef struct packed {
    srwa_pkg::srwa_state_e st;
    logic [31:0]           rdat;
    logic [16:0]           result;
    logic [15:0]           cnt;
    logic [7:0]            coarse, fine, cfg, best_coarse;
    logic [3:0]            sel;
    logic                  ack, step_fine, inv, en, done, fail;
    logic                  best_ok, best_inv, ph1, ph2, cap;
  } srwa_core_s;

  srwa_core_s  q_ff;
  srwa_core_s  nxt_q;
  logic [23:0] tap_sync, pos_flags;
  logic        req, mapped, wr_ctrl, wr_tad, wr_en, wr_cfg, launch;
  logic [9:0]  idx;
  logic [7:0]  cfg_eff;
  logic [15:0] settle_load;

  srwa_position_detector u_det (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tap_raw_i  (tap_raw_i),
    .tap_sync_o (tap_sync),
    .flags_o    (pos_flags)
  );

  assign req    = wb_cyc_i & wb_stb_i & ~q_ff.ack;
  assign idx    = wb_adr_i[11:2];
  assign mapped = (wb_adr_i[31:12] == 20'h00000);
  assign wr_ctrl = req & wb_we_i & mapped & wb_sel_i[0] &
                   (idx == srwa_pkg::IDX_CLK_CTRL);
  assign wr_tad  = req & wb_we_i & mapped & (idx == srwa_pkg::IDX_TAD);
  assign wr_en   = req & wb_we_i & mapped & wb_sel_i[0] &
                   (idx == srwa_pkg::IDX_CAL_EN);
  assign wr_cfg  = req & wb_we_i & mapped & wb_sel_i[0] &
                   (idx == srwa_pkg::IDX_CAL_CFG);
  assign launch  = wr_en & wb_dat_i[srwa_pkg::EN_BIT] & ~q_ff.en;
  // a zero config would skip the settling wait, so it counts as one
  assign cfg_eff = (q_ff.cfg == 8'h00) ? 8'h01 : q_ff.cfg;
  assign settle_load = 16'(srwa_pkg::SETTLE_CYC) * 16'(cfg_eff);

  always_comb
  begin
    logic       found, new_ok, new_inv;
    logic [7:0] cand, new_coarse;
    found      = 1'b0;
    cand       = 8'h00;
    new_ok     = q_ff.best_ok;
    new_inv    = q_ff.best_inv;
    new_coarse = q_ff.best_coarse;
    nxt_q      = q_ff;
    nxt_q.ph1 = clk_fall_leads_i;
    nxt_q.ph2 = q_ff.ph1;
    nxt_q.cap = tap_sync[q_ff.sel];
    // bus answer and read data, one cycle after the request
    nxt_q.ack  = req;
    nxt_q.rdat = 32'h00000000;
    if (req && !wb_we_i && mapped)
    begin
      case (idx)
        srwa_pkg::IDX_CLK_CTRL:
          nxt_q.rdat = {27'h0000000, q_ff.step_fine, q_ff.sel};
        srwa_pkg::IDX_POS_LOW:  nxt_q.rdat = {24'h000000, pos_flags[7:0]};
        srwa_pkg::IDX_POS_MID:  nxt_q.rdat = {24'h000000, pos_flags[15:8]};
        srwa_pkg::IDX_POS_HIGH: nxt_q.rdat = {24'h000000, pos_flags[23:16]};
        srwa_pkg::IDX_TAD:
          nxt_q.rdat = {15'h0000, q_ff.inv, q_ff.coarse, q_ff.fine};
        srwa_pkg::IDX_CAL_EN:   nxt_q.rdat = {31'h00000000, q_ff.en};
        srwa_pkg::IDX_CAL_CFG:  nxt_q.rdat = {24'h000000, q_ff.cfg};
        srwa_pkg::IDX_CAL_STAT:
          nxt_q.rdat = {7'h00, q_ff.result, 5'h00,
                        (q_ff.st == srwa_pkg::ST_COARSE) ||
                        (q_ff.st == srwa_pkg::ST_FINE),
                        q_ff.fail, q_ff.done};
        default:                nxt_q.rdat = 32'h00000000;
      endcase
    end
    // four bits reach taps 0 to 15
    if (wr_ctrl)
    begin
      nxt_q.sel = wb_dat_i[srwa_pkg::CTRL_SEL_LSB +: srwa_pkg::SEL_W];
      nxt_q.step_fine = wb_dat_i[srwa_pkg::CTRL_FINE_BIT];
    end
    if (wr_cfg)
      nxt_q.cfg = wb_dat_i[7:0];
    if (wr_tad && !q_ff.en)
    begin
      if (wb_sel_i[0])
        nxt_q.fine = wb_dat_i[srwa_pkg::DLY_FINE_LSB +: srwa_pkg::DLY_W];
      if (wb_sel_i[1])
        nxt_q.coarse = wb_dat_i[srwa_pkg::DLY_COARSE_LSB +: srwa_pkg::DLY_W];
      if (wb_sel_i[2])
        nxt_q.inv = wb_dat_i[srwa_pkg::DLY_INV_BIT];
    end
    if (wr_en)
      nxt_q.en = wb_dat_i[srwa_pkg::EN_BIT];
    if (q_ff.cnt != 16'h0000)
      nxt_q.cnt = q_ff.cnt - 16'h0001;
    case (q_ff.st)
      srwa_pkg::ST_IDLE: nxt_q.st = srwa_pkg::ST_IDLE;
      srwa_pkg::ST_COARSE:
      begin
        if (q_ff.cnt == 16'h0000)
        begin
          found = ~q_ff.ph2;
          cand  = (q_ff.coarse == 8'h00) ? 8'h00 : q_ff.coarse - 8'h01;
          if (found && (!q_ff.best_ok || cand < q_ff.best_coarse))
          begin
            new_ok     = 1'b1;
            new_inv    = q_ff.inv;
            new_coarse = cand;
          end
          nxt_q.best_ok     = new_ok;
          nxt_q.best_inv    = new_inv;
          nxt_q.best_coarse = new_coarse;
          nxt_q.cnt         = settle_load;
          if (!found && q_ff.coarse != srwa_pkg::DLY_MAX)
            nxt_q.coarse = q_ff.coarse + 8'h01;
          else if (!q_ff.inv)
          begin
            nxt_q.inv    = 1'b1;
            nxt_q.coarse = srwa_pkg::RST_DLY;
          end
          else if (new_ok)
          begin
            nxt_q.inv    = new_inv;
            nxt_q.coarse = new_coarse;
            nxt_q.fine   = srwa_pkg::RST_DLY;
            nxt_q.st     = srwa_pkg::ST_FINE;
          end
          else
          begin
            // no alignment in either polarity
            nxt_q.inv    = 1'b0;
            nxt_q.coarse = srwa_pkg::RST_DLY;
            nxt_q.fine   = srwa_pkg::RST_DLY;
            nxt_q.fail   = 1'b1;
            nxt_q.done   = 1'b1;
            nxt_q.result = '0;
            nxt_q.st     = srwa_pkg::ST_DONE;
          end
        end
      end
      srwa_pkg::ST_FINE:
      begin
        if (q_ff.cnt == 16'h0000)
        begin
          if (q_ff.ph2 && q_ff.fine != srwa_pkg::DLY_MAX)
          begin
            nxt_q.fine = q_ff.fine + 8'h01;
            nxt_q.cnt  = settle_load;
          end
          else
          begin
            nxt_q.done   = 1'b1;
            nxt_q.result = {q_ff.inv, q_ff.coarse, q_ff.fine};
            nxt_q.st     = srwa_pkg::ST_DONE;
          end
        end
      end
      srwa_pkg::ST_DONE: nxt_q.st = srwa_pkg::ST_DONE;
      default:           nxt_q.st = srwa_pkg::ST_IDLE;
    endcase
    // dropping enable mid-search leaves the delay where it stood, after any step due in that same cycle
    if (wr_en && !wb_dat_i[srwa_pkg::EN_BIT] &&
        q_ff.st != srwa_pkg::ST_DONE)
      nxt_q.st = srwa_pkg::ST_IDLE;
    if (launch)
    begin
      nxt_q.done        = 1'b0;
      nxt_q.fail        = 1'b0;
      nxt_q.best_ok     = 1'b0;
      nxt_q.best_inv    = 1'b0;
      nxt_q.best_coarse = srwa_pkg::RST_DLY;
      nxt_q.inv         = 1'b0;
      nxt_q.coarse      = srwa_pkg::RST_DLY;
      nxt_q.fine        = srwa_pkg::RST_DLY;
      nxt_q.cnt         = settle_load;
      nxt_q.st          = srwa_pkg::ST_COARSE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_ff           <= '0;
      q_ff.st        <= srwa_pkg::ST_IDLE;
      q_ff.sel       <= srwa_pkg::RST_SEL;
      q_ff.step_fine <= srwa_pkg::RST_STEP_FINE;
      q_ff.cfg       <= srwa_pkg::RST_CFG;
    end
    else
      q_ff <= nxt_q;
  end

  assign wb_dat_o                  = q_ff.rdat;
  assign wb_ack_o                  = q_ff.ack;
  assign reference_sample_select_o = q_ff.sel;
  assign position_step_fine_o      = q_ff.step_fine;
  assign sysref_captured_o         = q_ff.cap;
  assign clock_invert_delay_o      = q_ff.inv;
  assign aperture_coarse_delay_o   = q_ff.coarse;
  assign aperture_fine_delay_o     = q_ff.fine;
  assign refcal_done_o             = q_ff.done;

  property p_pos_read;
    @(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == 32'h000000b8 |=>
      wb_ack_o && wb_dat_o == {24'h000000, $past(pos_flags[23:16])};
  endproperty
  a_pos_read: assert property (p_pos_read)
    else $error("high position byte read wrong");
  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i, 1) |-> sysref_captured_o ==
      $past(tap_sync[reference_sample_select_o]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("reference not sampled at selected tap");
  property p_step_fine;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> position_step_fine_o == $past(wb_dat_i[4]);
  endproperty
  a_step_fine: assert property (p_step_fine)
    else $error("step-fine bit not applied");
  property p_launch_clear;
    @(posedge clk_i) disable iff (rst_i)
    launch |=> !refcal_done_o && q_ff.st == srwa_pkg::ST_COARSE
      && aperture_coarse_delay_o == 8'h00 ##1 !refcal_done_o;
  endproperty
  a_launch_clear: assert property (p_launch_clear)
    else $error("launch did not clear done");
  property p_done_result;
    @(posedge clk_i) disable iff (rst_i)
    $rose(refcal_done_o) && !q_ff.fail |-> q_ff.result ==
      {clock_invert_delay_o, aperture_coarse_delay_o, aperture_fine_delay_o};
  endproperty
  a_done_result: assert property (p_done_result)
    else $error("result differs from applied delay");
  property p_done_cause;
    @(posedge clk_i) disable iff (rst_i)
    $rose(refcal_done_o) |-> $past(q_ff.st) == srwa_pkg::ST_FINE ||
      $past(q_ff.st) == srwa_pkg::ST_COARSE;
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done raised outside a search");
  property p_hold_tad;
    @(posedge clk_i) disable iff (rst_i)
    wr_tad && q_ff.en && q_ff.st == srwa_pkg::ST_DONE && !launch |=>
      $stable(aperture_fine_delay_o) && $stable(aperture_coarse_delay_o);
  endproperty
  a_hold_tad: assert property (p_hold_tad)
    else $error("manual write changed calibrated delay");
  property p_fine_entry;
    @(posedge clk_i) disable iff (rst_i)
    q_ff.st == srwa_pkg::ST_COARSE && nxt_q.st == srwa_pkg::ST_FINE |=>
      clock_invert_delay_o == q_ff.best_inv &&
      aperture_coarse_delay_o == q_ff.best_coarse &&
      aperture_fine_delay_o == 8'h00;
  endproperty
  a_fine_entry: assert property (p_fine_entry)
    else $error("fine sweep not started from best coarse");
  property p_coarse_step;
    @(posedge clk_i) disable iff (rst_i)
    q_ff.st == srwa_pkg::ST_COARSE && q_ff.cnt == 16'h0000 && q_ff.ph2
      && aperture_coarse_delay_o != 8'hff && !launch && !wr_en |=>
      aperture_coarse_delay_o == $past(aperture_coarse_delay_o) + 8'h01;
  endproperty
  a_coarse_step: assert property (p_coarse_step)
    else $error("coarse sweep did not advance");

  c_launch: cover property (@(posedge clk_i) disable iff (rst_i) launch);
  c_done_ok: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(refcal_done_o) && !q_ff.fail);
  c_fail: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(q_ff.fail));
  c_manual: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_tad && !q_ff.en);

endmodule

// >>> dv/srwa_ref_source.sv
`timescale 1ns/1ps
module srwa_ref_source (
  input  wire logic [4:0]  edge_pos_i,
  input  wire logic [15:0] target_norm_i,
  input  wire logic [15:0] target_inv_i,
  input  wire logic        clock_invert_delay_i,
  input  wire logic [7:0]  aperture_coarse_delay_i,
  input  wire logic [7:0]  aperture_fine_delay_i,
  output logic      [23:0] tap_raw_o,
  output logic             clk_fall_leads_o
);
  // periodic reference, later taps see it high
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      tap_raw_o[i] = (5'(i) >= edge_pos_i);
    end
  end

  assign clk_fall_leads_o =
    {aperture_coarse_delay_i, aperture_fine_delay_i} <
    (clock_invert_delay_i ? target_inv_i : target_norm_i);
endmodule

// >>> dv/test_sysref_window_autocal.sv
`timescale 1ns/1ps
module test_sysref_window_autocal;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [31:0] wb_adr    = 32'h0;
  logic [3:0]  wb_sel    = 4'h0;
  logic [31:0] wb_wdat   = 32'h0;
  logic [4:0]  edge_pos  = 5'h18;
  logic [15:0] tgt_norm  = 16'hffff;
  logic [15:0] tgt_inv   = 16'hffff;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [23:0] tap_raw;
  logic        leads;
  logic [3:0]  sel;
  logic        step_fine;
  logic        captured;
  logic        inv;
  logic [7:0]  coarse;
  logic [7:0]  fine;
  logic        done;
  int          num_errors      = 0;
  int          samples_checked = 0;

  always #10 clk_i = ~clk_i;

  srwa_sysref_window_autocal u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .tap_raw_i(tap_raw), .clk_fall_leads_i(leads),
    .reference_sample_select_o(sel), .position_step_fine_o(step_fine),
    .sysref_captured_o(captured), .clock_invert_delay_o(inv),
    .aperture_coarse_delay_o(coarse), .aperture_fine_delay_o(fine),
    .refcal_done_o(done));

  srwa_ref_source u_src (
    .edge_pos_i(edge_pos), .target_norm_i(tgt_norm),
    .target_inv_i(tgt_inv), .clock_invert_delay_i(inv),
    .aperture_coarse_delay_i(coarse), .aperture_fine_delay_i(fine),
    .tap_raw_o(tap_raw), .clk_fall_leads_o(leads));

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ba(input logic [9:0] idx);
    return {20'h00000, idx, 2'b00};
  endfunction

  task automatic wb(input logic we, input logic [31:0] adr,
                    input logic [3:0] bsel, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= bsel;
    wb_wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
      num_errors++;
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ba(idx), 4'hf, d, q);
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] q);
    wb(1'b0, ba(idx), 4'hf, 32'h0, q);
  endtask

  task automatic getf(output logic [23:0] f);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    repeat (5) @(posedge clk_i);
    rd(srwa_pkg::IDX_POS_LOW, a);
    rd(srwa_pkg::IDX_POS_MID, b);
    rd(srwa_pkg::IDX_POS_HIGH, c);
    f = {c[7:0], b[7:0], a[7:0]};
  endtask

  task automatic t_reset;
    logic [31:0] q;
    rd(srwa_pkg::IDX_CLK_CTRL, q);
    chk(q, 32'h10);
    rd(srwa_pkg::IDX_TAD, q);
    chk(q, 32'h0);
    rd(srwa_pkg::IDX_CAL_CFG, q);
    chk(q, 32'h1);
    rd(srwa_pkg::IDX_CAL_STAT, q);
    chk(q, 32'h0);
    // upper address bits set must not alias the control register
    wb(1'b1, 32'h0000_10a4, 4'hf, 32'h0, q);
    rd(srwa_pkg::IDX_CLK_CTRL, q);
    chk(q, 32'h10);
    rd(10'h3ff, q);
    chk(q, 32'h0);
  endtask

  task automatic t_position;
    logic [23:0] f;
    logic [31:0] q;
    getf(f);
    chk({8'h00, f}, 32'h0080_0001);
    edge_pos <= 5'h00;
    getf(f);
    chk({8'h00, f}, 32'h0080_0001);
    edge_pos <= 5'h0a;
    getf(f);
    chk({8'h00, f & 24'hfff9ff}, 32'h0080_0001);
    chk({31'h0, |f[10:9]}, 32'h1);
    wr(srwa_pkg::IDX_POS_LOW, 32'hff);
    rd(srwa_pkg::IDX_POS_LOW, q);
    chk(q, {24'h0, f[7:0]});
  endtask

  task automatic t_select;
    logic [31:0] q;
    wr(srwa_pkg::IDX_CLK_CTRL, 32'h09);
    chk({27'h0, step_fine, sel}, 32'h09);
    repeat (3) @(posedge clk_i);
    chk({31'h0, captured}, 32'h0);
    wr(srwa_pkg::IDX_CLK_CTRL, 32'h0a);
    repeat (3) @(posedge clk_i);
    chk({31'h0, captured}, 32'h1);
    wr(srwa_pkg::IDX_CLK_CTRL, 32'h3f);
    rd(srwa_pkg::IDX_CLK_CTRL, q);
    chk(q, 32'h1f);
    chk({27'h0, step_fine, sel}, 32'h1f);
    wr(srwa_pkg::IDX_CLK_CTRL, 32'h10);
  endtask

  task automatic t_cal(input logic [15:0] tn, input logic [15:0] ti,
                       input logic [31:0] exp);
    logic [31:0] q;
    int          n;
    tgt_norm <= tn;
    tgt_inv  <= ti;
    // config first, then enable, no other calibration
    wr(srwa_pkg::IDX_CAL_CFG, 32'h1);
    wr(srwa_pkg::IDX_CAL_EN, 32'h0);
    wr(srwa_pkg::IDX_CAL_EN, 32'h1);
    rd(srwa_pkg::IDX_CAL_STAT, q);
    chk(q & 32'h1, 32'h0);
    n = 0;
    do
    begin
      rd(srwa_pkg::IDX_CAL_STAT, q);
      n++;
    end while (q[0] !== 1'b1 && n < 2000);
    chk(q, exp);
    chk({15'h0, inv, coarse, fine}, {15'h0, exp[24:8]});
    chk({31'h0, done}, 32'h1);
    wr(srwa_pkg::IDX_TAD, 32'h1ffff);
    rd(srwa_pkg::IDX_TAD, q);
    chk(q, {15'h0, exp[24:8]});
    wr(srwa_pkg::IDX_CAL_EN, 32'h0);
  endtask

  task automatic t_manual;
    logic [31:0] q;
    chk({31'h0, done}, 32'h1);
    wr(srwa_pkg::IDX_TAD, 32'h1ffff);
    chk({15'h0, inv, coarse, fine}, 32'h1ffff);
    wb(1'b1, ba(srwa_pkg::IDX_TAD), 4'h1, 32'h0, q);
    rd(srwa_pkg::IDX_TAD, q);
    chk(q, 32'h1ff00);
  endtask

  task automatic t_abort;
    logic [31:0] q;
    tgt_norm <= 16'hffff;
    tgt_inv  <= 16'hffff;
    wr(srwa_pkg::IDX_CAL_EN, 32'h1);
    repeat (100) @(posedge clk_i);
    wr(srwa_pkg::IDX_CAL_EN, 32'h0);
    rd(srwa_pkg::IDX_CAL_STAT, q);
    chk(q & 32'h7, 32'h0);
    chk({31'h0, done}, 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_position;
    t_select;
    t_cal(16'h0240, 16'h0520, 32'h0002_4001);
    t_manual;
    t_cal(16'h0800, 16'h0130, 32'h0101_3001);
    t_cal(16'h0150, 16'h0160, 32'h0001_5001);
    t_abort;
    t_cal(16'hffff, 16'hffff, 32'h0000_0003);
    tally_and_finish;
  end

  // hang guard well above the longest search sequence
  initial
  begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    tally_and_finish;
  end
endmodule
